/* File: rtl/bus_clock_gate_and_reset_ctrl.sv */
// clock gating, bus clock dividers, self-clearing resets and clock status over axi4-lite
// What this block does
// [R01] status bit 2 mirrors pll lock
// [R02] sticky bit 1 records pll lock loss
// [R03] failed external source forces fast oscillator, flag
// [R04] flag with enable raises interrupt request
// [R05] clock fail flag cleared only by reset
// [R06] 16-bit tick calibration, reset 0x2327
// [R07] core bus divider codes 0-4, rest reserved
// [R08] software enables option-map clock before rewrite
// [R09] bit1 gates checksum clock, bit0 dma clock
// [R10] bit 23 gates each peripheral bus clock
// [R11] first peripheral bus divider, divide 1-128
// [R12] first bus per-peripheral clock gates, bits 8-0
// [R13] second peripheral bus divider, divide 1-128
// [R14] second bus gates bits 7,4,3-0 only
// [R15] third peripheral bus divider, divide 1-128
// [R16] software pairs led clock with segment display
// [R17] third bus bit0 led clock and ram
// [R18] write one resets, hardware clears, zero ignored
// [R19] core reset: checksum bit1, dma bit0
// [R20] first bus reset bits 8-0 per peripheral
// [R21] irq enable sits at bit 15
// [R22] reset held one full bus clock period
// [R23] reserved bits read zero, writes ignored
// [R24] divider changes apply only at period end
module bus_clock_gate_and_reset_ctrl (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [31:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [31:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire clkrst_pkg::clock_monitor_t monitor,
	output logic switch_to_fast_osc,
	output logic clock_fail_irq,
	output logic core_clk_en,
	output logic checksum_clk_en,
	output logic dma_clk_en,
	output logic option_map_clk_en,
	output logic [2:0] pbus_clk_en,
	output logic [8:0] first_periph_clk_en,
	output logic [7:0] second_periph_clk_en,
	output logic [2:0] third_periph_clk_en,
	output logic segment_ram_enable,
	output logic [1:0] core_periph_reset,
	output logic [8:0] first_periph_reset
);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [6:0] div_limit(input logic [2:0] code);
		div_limit = 7'h7f >> (3'h7 - code);
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
		input logic [3:0] strb, input logic [31:0] allowed);
		logic [31:0] m;
		m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & allowed;
		merge = (old & ~m) | (data & m);
	endfunction

	// ----------------------------------------
	// axi4-lite slave state
	// ----------------------------------------
	logic aw_held_reg, aw_held_next, w_held_reg, w_held_next;
	logic [7:0] waddr_reg, waddr_next;
	logic [31:0] wdata_reg, wdata_next;
	logic [3:0] wstrb_reg, wstrb_next;
	logic bvalid_reg, bvalid_next, awready_reg, awready_next, wready_reg, wready_next;
	logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
	logic rvalid_reg, rvalid_next, arready_reg, arready_next;
	logic [31:0] rdata_reg, rdata_next;
	logic wr_fire;

	// ----------------------------------------
	// control and status registers
	// ----------------------------------------
	logic [31:0] core_cfg_reg, core_cfg_next, tick_calibration_value_reg, tick_calibration_value_next, sys_cfg_reg, sys_cfg_next;
	localparam int NUM_PBUS_L = clkrst_pkg::NUM_PBUS;
	logic [31:0] p_cfg_reg [NUM_PBUS_L], p_cfg_next [NUM_PBUS_L];
	logic [clkrst_pkg::RST_W-1:0] rst_reg, rst_next, armed_reg, armed_next, rst_set, rst_tick;
	logic locked_reg, lost_reg, lost_next, fail_reg, fail_next;
	logic fast_osc_reg, irq_reg, fail_set;
	logic [31:0] status_word, cand;

	// ----------------------------------------
	// dividers
	// ----------------------------------------
	logic [6:0] hcnt_reg, hcnt_next;
	logic [2:0] hdiv_reg, hdiv_next;
	logic htick;
	logic [6:0] pcnt_reg [NUM_PBUS_L], pcnt_next [NUM_PBUS_L];
	logic [2:0] pdiv_reg [NUM_PBUS_L], pdiv_next [NUM_PBUS_L];
	logic [NUM_PBUS_L-1:0] ptick, pgate;
	logic core_en_reg, crc_en_reg, dma_en_reg;
	logic [2:0] pbus_en_reg;
	logic [8:0] p0_en_reg;
	logic [7:0] p1_en_reg;
	logic [2:0] p2_en_reg;

	// ----------------------------------------
	// register bus handshake
	// ----------------------------------------
	assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;

	always_comb begin
		aw_held_next = aw_held_reg;
		w_held_next = w_held_reg;
		waddr_next = waddr_reg;
		wdata_next = wdata_reg;
		wstrb_next = wstrb_reg;
		bvalid_next = bvalid_reg;
		bresp_next = bresp_reg;
		if (awvalid && awready_reg) begin
			aw_held_next = 1'b1;
			waddr_next = awaddr[7:0];
		end
		if (wvalid && wready_reg) begin
			w_held_next = 1'b1;
			wdata_next = wdata;
			wstrb_next = wstrb;
		end
		if (bvalid_reg && bready) begin
			bvalid_next = 1'b0;
		end
		if (wr_fire) begin
			aw_held_next = 1'b0;
			w_held_next = 1'b0;
			bvalid_next = 1'b1;
			case (waddr_reg)
				clkrst_pkg::OFF_CORE_CFG, clkrst_pkg::OFF_CORE_RST, clkrst_pkg::OFF_SYS_CFG,
				clkrst_pkg::OFF_STATUS, clkrst_pkg::OFF_TICK_CALIBRATION_VALUE, clkrst_pkg::OFF_P0_CFG,
				clkrst_pkg::OFF_P0_RST, clkrst_pkg::OFF_P1_CFG,
				clkrst_pkg::OFF_P2_CFG: bresp_next = clkrst_pkg::RESP_OKAY;
				default: bresp_next = clkrst_pkg::RESP_SLVERR;
			endcase
		end
		// one write in flight: stall new address and data until the response is gone
		awready_next = !aw_held_next && !bvalid_next;
		wready_next = !w_held_next && !bvalid_next;
	end

	assign status_word = {29'h0, locked_reg, lost_reg, fail_reg}; // [R01] [R02] [R23]

	always_comb begin
		rvalid_next = rvalid_reg;
		rdata_next = rdata_reg;
		rresp_next = rresp_reg;
		if (rvalid_reg && rready) begin
			rvalid_next = 1'b0;
		end
		if (arvalid && arready_reg) begin
			rvalid_next = 1'b1;
			rresp_next = clkrst_pkg::RESP_OKAY;
			case (araddr[7:0])
				clkrst_pkg::OFF_CORE_CFG: rdata_next = core_cfg_reg;
				clkrst_pkg::OFF_CORE_RST: rdata_next = {30'h0, rst_reg[1:0]};
				clkrst_pkg::OFF_SYS_CFG: rdata_next = sys_cfg_reg;
				clkrst_pkg::OFF_STATUS: rdata_next = status_word;
				clkrst_pkg::OFF_TICK_CALIBRATION_VALUE: rdata_next = tick_calibration_value_reg;
				clkrst_pkg::OFF_P0_CFG: rdata_next = p_cfg_reg[0];
				clkrst_pkg::OFF_P0_RST: rdata_next = {23'h0, rst_reg[10:2]};
				clkrst_pkg::OFF_P1_CFG: rdata_next = p_cfg_reg[1];
				clkrst_pkg::OFF_P2_CFG: rdata_next = p_cfg_reg[2];
				default: begin
					rdata_next = 32'h0000_0000;
					rresp_next = clkrst_pkg::RESP_SLVERR;
				end
			endcase
		end
		arready_next = !rvalid_next;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			waddr_reg <= 8'h00;
			wdata_reg <= 32'h0000_0000;
			wstrb_reg <= 4'h0;
			bvalid_reg <= 1'b0;
			bresp_reg <= 2'h0;
			awready_reg <= 1'b0;
			wready_reg <= 1'b0;
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			rresp_reg <= 2'h0;
			arready_reg <= 1'b0;
		end else begin
			aw_held_reg <= aw_held_next;
			w_held_reg <= w_held_next;
			waddr_reg <= waddr_next;
			wdata_reg <= wdata_next;
			wstrb_reg <= wstrb_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			awready_reg <= awready_next;
			wready_reg <= wready_next;
			rvalid_reg <= rvalid_next;
			rdata_reg <= rdata_next;
			rresp_reg <= rresp_next;
			arready_reg <= arready_next;
		end
	end

	// ----------------------------------------
	// configuration registers and self-clearing resets
	// ----------------------------------------
	assign rst_tick = {{clkrst_pkg::P0_RST_W{ptick[0]}}, {clkrst_pkg::CORE_RST_W{htick}}};
	assign fail_set = monitor.source_external && monitor.source_failed;

	always_comb begin
		core_cfg_next = core_cfg_reg;
		tick_calibration_value_next = tick_calibration_value_reg;
		sys_cfg_next = sys_cfg_reg;
		for (int i = 0; i < NUM_PBUS_L; i++) begin
			p_cfg_next[i] = p_cfg_reg[i];
		end
		rst_set = '0;
		cand = merge(core_cfg_reg, wdata_reg, wstrb_reg, clkrst_pkg::CORE_CFG_MASK); // [R23]
		if (wr_fire) begin
			case (waddr_reg)
				clkrst_pkg::OFF_CORE_CFG: begin
					// reserved divider codes leave the running ratio untouched
					if (cand[clkrst_pkg::DIV_MSB:clkrst_pkg::DIV_LSB] > clkrst_pkg::CORE_DIV_MAX) begin // [R07]
						cand[clkrst_pkg::DIV_MSB:clkrst_pkg::DIV_LSB] =
							core_cfg_reg[clkrst_pkg::DIV_MSB:clkrst_pkg::DIV_LSB];
					end
					core_cfg_next = cand;
				end
				clkrst_pkg::OFF_TICK_CALIBRATION_VALUE: tick_calibration_value_next = merge(tick_calibration_value_reg, wdata_reg, wstrb_reg,
					clkrst_pkg::TICK_CALIBRATION_VALUE_MASK); // [R06]
				clkrst_pkg::OFF_SYS_CFG: sys_cfg_next = merge(sys_cfg_reg, wdata_reg, wstrb_reg,
					clkrst_pkg::SYS_CFG_MASK); // [R21]
				clkrst_pkg::OFF_P0_CFG: p_cfg_next[0] = merge(p_cfg_reg[0], wdata_reg, wstrb_reg,
					clkrst_pkg::P0_CFG_MASK);
				clkrst_pkg::OFF_P1_CFG: p_cfg_next[1] = merge(p_cfg_reg[1], wdata_reg, wstrb_reg,
					clkrst_pkg::P1_CFG_MASK); // [R14]
				clkrst_pkg::OFF_P2_CFG: p_cfg_next[2] = merge(p_cfg_reg[2], wdata_reg, wstrb_reg,
					clkrst_pkg::P2_CFG_MASK);
				clkrst_pkg::OFF_CORE_RST: rst_set[1:0] = 2'(merge(32'h0, wdata_reg, wstrb_reg,
					clkrst_pkg::CORE_RST_MASK)); // [R19]
				clkrst_pkg::OFF_P0_RST: rst_set[10:2] = 9'(merge(32'h0, wdata_reg, wstrb_reg,
					clkrst_pkg::P0_RST_MASK)); // [R20]
				default: ;
			endcase
		end
		// a bit clears on the second bus tick it sees, so a full bus period passes; a fresh set wins
		rst_next = (rst_reg & ~(rst_tick & armed_reg)) | rst_set; // [R18] [R22]
		armed_next = ~rst_set & rst_next & (armed_reg | (rst_tick & rst_reg)); // [R22]
		lost_next = lost_reg | (locked_reg && !monitor.pll_locked); // [R02]
		fail_next = fail_reg | fail_set; // [R03] [R05]
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			core_cfg_reg <= clkrst_pkg::CORE_CFG_RESET;
			tick_calibration_value_reg <= clkrst_pkg::TICK_CALIBRATION_VALUE_RESET;
			sys_cfg_reg <= clkrst_pkg::ZERO_RESET;
			for (int i = 0; i < NUM_PBUS_L; i++) begin
				p_cfg_reg[i] <= clkrst_pkg::ZERO_RESET;
			end
			rst_reg <= '0;
			armed_reg <= '0;
			locked_reg <= 1'b0;
			lost_reg <= 1'b0;
			fail_reg <= 1'b0;
			fast_osc_reg <= 1'b0;
			irq_reg <= 1'b0;
		end else begin
			core_cfg_reg <= core_cfg_next;
			tick_calibration_value_reg <= tick_calibration_value_next;
			sys_cfg_reg <= sys_cfg_next;
			for (int i = 0; i < NUM_PBUS_L; i++) begin
				p_cfg_reg[i] <= p_cfg_next[i];
			end
			rst_reg <= rst_next;
			armed_reg <= armed_next;
			locked_reg <= monitor.pll_locked; // [R01]
			lost_reg <= lost_next;
			fail_reg <= fail_next;
			fast_osc_reg <= fast_osc_reg | fail_set; // [R03]
			irq_reg <= fail_next && sys_cfg_next[clkrst_pkg::IRQ_EN_BIT]; // [R04]
		end
	end

	// ----------------------------------------
	// core bus divider
	// ----------------------------------------
	assign htick = (hcnt_reg == div_limit(hdiv_reg));

	always_comb begin
		hcnt_next = hcnt_reg + 7'h01;
		hdiv_next = hdiv_reg;
		if (htick) begin
			hcnt_next = 7'h00;
			hdiv_next = core_cfg_reg[clkrst_pkg::DIV_MSB:clkrst_pkg::DIV_LSB]; // [R07] [R24]
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hcnt_reg <= 7'h00;
			hdiv_reg <= 3'h2;
		end else begin
			hcnt_reg <= hcnt_next;
			hdiv_reg <= hdiv_next;
		end
	end

	// ----------------------------------------
	// peripheral bus dividers, counted in core ticks
	// ----------------------------------------
	for (genvar g = 0; g < NUM_PBUS_L; g++) begin : g_pbus
		assign ptick[g] = htick && (pcnt_reg[g] == div_limit(pdiv_reg[g])); // [R11] [R13] [R15]
		assign pgate[g] = p_cfg_reg[g][clkrst_pkg::BUS_GATE_BIT]; // [R10]
		always_comb begin
			pcnt_next[g] = pcnt_reg[g];
			pdiv_next[g] = pdiv_reg[g];
			if (htick) begin
				pcnt_next[g] = pcnt_reg[g] + 7'h01;
			end
			if (ptick[g]) begin
				pcnt_next[g] = 7'h00;
				pdiv_next[g] = p_cfg_reg[g][clkrst_pkg::DIV_MSB:clkrst_pkg::DIV_LSB]; // [R24]
			end
		end
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				pcnt_reg[g] <= 7'h00;
				pdiv_reg[g] <= 3'h0;
			end else begin
				pcnt_reg[g] <= pcnt_next[g];
				pdiv_reg[g] <= pdiv_next[g];
			end
		end
	end

	// ----------------------------------------
	// gated clock enables
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			core_en_reg <= 1'b0;
			crc_en_reg <= 1'b0;
			dma_en_reg <= 1'b0;
			pbus_en_reg <= 3'h0;
			p0_en_reg <= 9'h000;
			p1_en_reg <= 8'h00;
			p2_en_reg <= 3'h0;
		end else begin
			core_en_reg <= htick;
			crc_en_reg <= htick && core_cfg_reg[clkrst_pkg::CRC_BIT]; // [R09]
			dma_en_reg <= htick && core_cfg_reg[clkrst_pkg::DMA_BIT]; // [R09]
			pbus_en_reg <= ptick & pgate; // [R10]
			p0_en_reg <= {9{ptick[0] && pgate[0]}} & p_cfg_reg[0][8:0]; // [R12]
			p1_en_reg <= {8{ptick[1] && pgate[1]}} & p_cfg_reg[1][7:0]; // [R14]
			p2_en_reg <= {3{ptick[2] && pgate[2]}} & p_cfg_reg[2][2:0]; // [R17]
		end
	end

	assign awready = awready_reg;
	assign wready = wready_reg;
	assign bvalid = bvalid_reg;
	assign bresp = bresp_reg;
	assign arready = arready_reg;
	assign rvalid = rvalid_reg;
	assign rdata = rdata_reg;
	assign rresp = rresp_reg;
	assign switch_to_fast_osc = fast_osc_reg;
	assign clock_fail_irq = irq_reg;
	assign core_clk_en = core_en_reg;
	assign checksum_clk_en = crc_en_reg;
	assign dma_clk_en = dma_en_reg;
	assign option_map_clk_en = core_cfg_reg[clkrst_pkg::OPT_MAP_BIT]; // [R08]
	assign pbus_clk_en = pbus_en_reg;
	assign first_periph_clk_en = p0_en_reg;
	assign second_periph_clk_en = p1_en_reg;
	assign third_periph_clk_en = p2_en_reg;
	assign segment_ram_enable = p_cfg_reg[2][clkrst_pkg::SEG_RAM_BIT]; // [R17]
	assign core_periph_reset = rst_reg[1:0];
	assign first_periph_reset = rst_reg[10:2];

	// ----------------------------------------
	// checks
	// ----------------------------------------
	logic [7:0] hgap_reg;
	logic [2:0] gapdiv_reg;
	logic gap_seen_reg;
	// a first bus tick has passed while the first bus reset bit 0 was held
	logic p0_seen_reg;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hgap_reg <= 8'h00;
			gapdiv_reg <= 3'h0;
			gap_seen_reg <= 1'b0;
			p0_seen_reg <= 1'b0;
		end else begin
			hgap_reg <= core_en_reg ? 8'h00 : hgap_reg + 8'h01;
			gapdiv_reg <= core_en_reg ? hdiv_reg : gapdiv_reg;
			gap_seen_reg <= gap_seen_reg | core_en_reg;
			p0_seen_reg <= !rst_set[2] && (p0_seen_reg || (ptick[0] && rst_reg[2]));
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence write_taken;
		wr_fire;
	endsequence
	sequence resp_held;
		bvalid[*1] ##0 !bready;
	endsequence

	lock_mirror_a: assert property (##1 status_word[2] == $past(monitor.pll_locked)) else $error("lock bit wrong"); // [R01]
	lock_lost_a: assert property ($fell(locked_reg) |=> lost_reg [*3]) else $error("lock loss not kept"); // [R02]
	fail_switch_a: assert property (fail_set |=> fail_reg && switch_to_fast_osc) else $error("no failover"); // [R03]
	fail_irq_a: assert property (fail_reg && sys_cfg_reg[15] |-> clock_fail_irq) else $error("irq missing"); // [R04]
	fail_sticky_a: assert property (fail_reg |=> fail_reg) else $error("fail flag cleared"); // [R05]
	core_period_a: assert property (core_en_reg && gap_seen_reg |-> hgap_reg == 8'(div_limit(gapdiv_reg))) // [R07]
		else $error("core period wrong");
	rst_hold_a: assert property ($fell(rst_reg[2]) |-> $past(ptick[0]) && $past(p0_seen_reg)) // [R22]
		else $error("reset too short");
	bus_gate_a: assert property (pbus_clk_en[0] |-> $past(p_cfg_reg[0][23])) else $error("gated bus ticked"); // [R10]
	wr_resp_a: assert property (write_taken |=> bvalid) else $error("response missing"); // [R18]
	resp_hold_a: assert property (resp_held |=> bvalid) else $error("response lost"); // [R18]
endmodule

/* File: rtl/clkrst_pkg.sv */
// constants and types for the bus clock gate and reset controller
package clkrst_pkg;
	// ----------------------------------------
	// register byte offsets
	// ----------------------------------------
	localparam logic [7:0] OFF_CORE_CFG = 8'h00;
	localparam logic [7:0] OFF_CORE_RST = 8'h04;
	localparam logic [7:0] OFF_SYS_CFG = 8'h14;
	localparam logic [7:0] OFF_STATUS = 8'h20;
	localparam logic [7:0] OFF_TICK_CALIBRATION_VALUE = 8'h28;
	localparam logic [7:0] OFF_P0_CFG = 8'h40;
	localparam logic [7:0] OFF_P0_RST = 8'h44;
	localparam logic [7:0] OFF_P1_CFG = 8'h48;
	localparam logic [7:0] OFF_P2_CFG = 8'h4c;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int FAIL_BIT = 0;
	localparam int LOST_BIT = 1;
	localparam int LOCKED_BIT = 2;
	localparam int IRQ_EN_BIT = 15;
	localparam int DIV_LSB = 20;
	localparam int DIV_MSB = 22;
	localparam int BUS_GATE_BIT = 23;
	localparam int OPT_MAP_BIT = 2;
	localparam int CRC_BIT = 1;
	localparam int DMA_BIT = 0;
	localparam int SEG_RAM_BIT = 0;
	localparam int CORE_RST_W = 2;
	localparam int P0_RST_W = 9;
	localparam int RST_W = CORE_RST_W + P0_RST_W;
	localparam int NUM_PBUS = 3;

	// ----------------------------------------
	// writable bits and reset values
	// ----------------------------------------
	localparam logic [31:0] CORE_CFG_MASK = 32'h0070_0007;
	localparam logic [31:0] P0_CFG_MASK = 32'h00f0_01ff;
	localparam logic [31:0] P1_CFG_MASK = 32'h00f0_009f;
	localparam logic [31:0] P2_CFG_MASK = 32'h00f0_0007;
	localparam logic [31:0] CORE_RST_MASK = 32'h0000_0003;
	localparam logic [31:0] P0_RST_MASK = 32'h0000_01ff;
	localparam logic [31:0] TICK_CALIBRATION_VALUE_MASK = 32'h0000_ffff;
	localparam logic [31:0] SYS_CFG_MASK = 32'h0000_8000;
	localparam logic [31:0] CORE_CFG_RESET = 32'h0020_0000;
	localparam logic [31:0] TICK_CALIBRATION_VALUE_RESET = 32'h0000_2327;
	localparam logic [31:0] ZERO_RESET = 32'h0000_0000;
	localparam logic [2:0] CORE_DIV_MAX = 3'h4;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ----------------------------------------
	// clock monitor inputs
	// ----------------------------------------
	typedef struct packed {
		logic pll_locked;
		logic source_external;
		logic source_failed;
	} clock_monitor_t;
endpackage

/* File: tb/axil_master.sv */
// axi4-lite master standing in for the processor core
module axil_master (
	input wire logic aclk,
	output logic [31:0] awaddr,
	output logic awvalid,
	input wire logic awready,
	output logic [31:0] wdata,
	output logic [3:0] wstrb,
	output logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	output logic bready,
	output logic [31:0] araddr,
	output logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	output logic rready
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		{awvalid, wvalid, bready, arvalid, rready} = 5'h0;
		{awaddr, wdata, araddr} = 96'h0;
		wstrb = 4'hf;
	end
	// a released payload shows its inverse, so a late sample never matches by luck
	task automatic wr(input logic [31:0] a, d, output logic [1:0] r);
		logic [1:0] open;
		open = 2'h3;
		@(posedge aclk);
		{awaddr, wdata} <= {a, d};
		{awvalid, wvalid, bready} <= 3'h7;
		while (open != 2'h0) begin
			@(posedge aclk);
			if (open[1] && awready === 1'b1) begin
				open[1] = 1'b0;
				awvalid <= 1'b0;
				awaddr <= ~a;
			end
			if (open[0] && wready === 1'b1) begin
				open[0] = 1'b0;
				wvalid <= 1'b0;
				wdata <= ~d;
			end
		end
		while (bvalid !== 1'b1) @(posedge aclk);
		r = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		{arvalid, rready} <= 2'h3;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		araddr <= ~a;
		while (rvalid !== 1'b1) @(posedge aclk);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
endmodule

/* File: tb/bus_clock_gate_and_reset_ctrl_tb_top.sv */
// self-checking bench for the bus clock gate and reset controller
module bus_clock_gate_and_reset_ctrl_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk;
	logic aresetn;
	logic [31:0] awaddr, wdata, araddr, rdata, rv, v;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, rr, core_periph_reset;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic switch_to_fast_osc, clock_fail_irq, core_clk_en, checksum_clk_en, dma_clk_en;
	logic option_map_clk_en, segment_ram_enable;
	logic [2:0] pbus_clk_en, third_periph_clk_en;
	logic [8:0] first_periph_clk_en, first_periph_reset;
	logic [7:0] second_periph_clk_en;
	clkrst_pkg::clock_monitor_t monitor;
	int n_errors = 0;
	int checks = 0;
	int cycles = 0;
	int g;
	bus_clock_gate_and_reset_ctrl i_dut (
		.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
		.bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .monitor,
		.switch_to_fast_osc, .clock_fail_irq, .core_clk_en, .checksum_clk_en, .dma_clk_en,
		.option_map_clk_en, .pbus_clk_en, .first_periph_clk_en, .second_periph_clk_en,
		.third_periph_clk_en, .segment_ram_enable, .core_periph_reset, .first_periph_reset
	);
	axil_master i_master (
		.aclk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
		.bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready
	);
	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end
	// ceiling is several times the expected run length
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			n_errors++;
			report_and_stop();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic w(input logic [31:0] a, d);
		i_master.wr(a, d, rr);
	endtask
	task automatic r(input logic [31:0] a, e);
		i_master.rd(a, rv, rr);
		chk(rv, e);
	endtask
	function automatic logic sig(input int s);
		case (s)
			0: return core_clk_en;
			4: return checksum_clk_en;
			5: return dma_clk_en;
			6: return |core_periph_reset;
			7: return |first_periph_reset;
			default: return pbus_clk_en[s - 1];
		endcase
	endfunction
	// a later gap is timed: a new divider code lands only at the end of a period
	task automatic gap(input int s, output int n);
		repeat (2) begin
			n = 0;
			@(negedge aclk);
			while (sig(s) !== 1'b1) @(negedge aclk);
			do begin
				@(negedge aclk);
				n++;
			end while (sig(s) !== 1'b1);
		end
	endtask
	task automatic watch(input int s, input int m, output int n);
		n = 0;
		v = 32'h0;
		repeat (m) begin
			@(negedge aclk);
			n += sig(s);
			v |= {12'h0, third_periph_clk_en, second_periph_clk_en, first_periph_clk_en};
		end
	endtask
	task automatic rst();
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
	endtask
	task automatic t_regs();
		r(clkrst_pkg::OFF_CORE_CFG, 32'h0020_0000);
		r(clkrst_pkg::OFF_TICK_CALIBRATION_VALUE, 32'h0000_2327);
		r(clkrst_pkg::OFF_P0_RST, 32'h0000_0000);
		w(clkrst_pkg::OFF_TICK_CALIBRATION_VALUE, 32'hffff_ffff);
		r(clkrst_pkg::OFF_TICK_CALIBRATION_VALUE, 32'h0000_ffff);
		w(clkrst_pkg::OFF_CORE_CFG, 32'hffff_ffff);
		r(clkrst_pkg::OFF_CORE_CFG, 32'h0020_0007);
		i_master.rd(32'h0000_0080, rv, rr);
		chk(rv, 32'h0000_0000);
		chk(rr, clkrst_pkg::RESP_SLVERR);
		i_master.wr(32'h0000_0080, 32'hffff_ffff, rr);
		chk(rr, clkrst_pkg::RESP_SLVERR);
		$display("t_regs done");
	endtask
	task automatic t_status();
		r(clkrst_pkg::OFF_STATUS, 32'h0000_0000);
		@(posedge aclk);
		monitor.pll_locked <= 1'b1;
		r(clkrst_pkg::OFF_STATUS, 32'h0000_0004);
		@(posedge aclk);
		monitor.pll_locked <= 1'b0;
		monitor.source_failed <= 1'b1;
		r(clkrst_pkg::OFF_STATUS, 32'h0000_0002);
		@(posedge aclk);
		monitor.source_external <= 1'b1;
		@(posedge aclk);
		monitor.source_failed <= 1'b0;
		r(clkrst_pkg::OFF_STATUS, 32'h0000_0003);
		chk(switch_to_fast_osc, 1'b1);
		chk(clock_fail_irq, 1'b0);
		w(clkrst_pkg::OFF_STATUS, 32'hffff_ffff);
		r(clkrst_pkg::OFF_STATUS, 32'h0000_0003);
		w(clkrst_pkg::OFF_SYS_CFG, 32'hffff_ffff);
		r(clkrst_pkg::OFF_SYS_CFG, 32'h0000_8000);
		chk(clock_fail_irq, 1'b1);
		w(clkrst_pkg::OFF_SYS_CFG, 32'h0000_0000);
		@(negedge aclk);
		chk(clock_fail_irq, 1'b0);
		rst();
		r(clkrst_pkg::OFF_STATUS, 32'h0000_0000);
		chk(switch_to_fast_osc, 1'b0);
		$display("t_status done");
	endtask
	task automatic t_core();
		gap(0, g);
		chk(g, 4);
		for (int c = 0; c < 5; c++) begin
			w(clkrst_pkg::OFF_CORE_CFG, 32'h3 | (c << 20));
			gap(0, g);
			chk(g, 1 << c);
		end
		gap(4, g);
		chk(g, 16);
		w(clkrst_pkg::OFF_CORE_CFG, 32'h0050_0005);
		r(clkrst_pkg::OFF_CORE_CFG, 32'h0040_0005);
		watch(4, 40, g);
		chk(g, 0);
		gap(5, g);
		chk(g, 16);
		chk(option_map_clk_en, 1'b1);
		w(clkrst_pkg::OFF_CORE_CFG, 32'h0000_0004);
		$display("t_core done");
	endtask
	task automatic t_pbus();
		logic [7:0] a [3];
		a = '{clkrst_pkg::OFF_P0_CFG, clkrst_pkg::OFF_P1_CFG, clkrst_pkg::OFF_P2_CFG};
		for (int b = 0; b < 3; b++) begin
			for (int c = 0; c < 8; c++) begin
				w(a[b], 32'h0080_0000 | (c << 20));
				gap(b + 1, g);
				chk(g, 1 << c);
			end
			w(a[b], 32'h0070_0000);
			watch(b + 1, 300, g);
			chk(g, 0);
		end
		$display("t_pbus done");
	endtask
	task automatic t_gates();
		w(clkrst_pkg::OFF_P0_CFG, 32'h0080_00a5);
		w(clkrst_pkg::OFF_P1_CFG, 32'hffff_ffff);
		w(clkrst_pkg::OFF_P2_CFG, 32'h0080_0003); // led clock enabled with the display
		watch(0, 300, g);
		chk(v[8:0], 9'h0a5);
		chk(v[16:9], 8'h9f);
		chk(v[19:17], 3'h3);
		chk(segment_ram_enable, 1'b1);
		r(clkrst_pkg::OFF_P1_CFG, 32'h00f0_009f);
		w(clkrst_pkg::OFF_P2_CFG, 32'hffff_ffff);
		r(clkrst_pkg::OFF_P2_CFG, 32'h00f0_0007);
		w(clkrst_pkg::OFF_P2_CFG, 32'h0080_0002);
		@(negedge aclk);
		chk(segment_ram_enable, 1'b0);
		w(clkrst_pkg::OFF_P0_CFG, 32'hffff_ffff);
		r(clkrst_pkg::OFF_P0_CFG, 32'h00f0_01ff);
		$display("t_gates done");
	endtask
	// slow core clock so the pulse outlasts the bus cycles around it
	task automatic t_rst();
		w(clkrst_pkg::OFF_CORE_CFG, 32'h0040_0000);
		w(clkrst_pkg::OFF_CORE_RST, 32'hffff_fffe);
		@(negedge aclk);
		chk(core_periph_reset, 2'h2);
		r(clkrst_pkg::OFF_CORE_RST, 32'h0000_0002);
		watch(6, 60, g);
		chk(g >= 8 && g <= 32, 1'b1);
		chk(core_periph_reset, 2'h0);
		w(clkrst_pkg::OFF_CORE_RST, 32'h0000_0001);
		w(clkrst_pkg::OFF_CORE_RST, 32'h0000_0000);
		@(negedge aclk);
		chk(core_periph_reset, 2'h1);
		watch(6, 60, g);
		chk(core_periph_reset, 2'h0);
		w(clkrst_pkg::OFF_CORE_CFG, 32'h0000_0000);
		// the slow bus period left from before must run out first
		w(clkrst_pkg::OFF_P0_CFG, 32'h00b0_0000);
		gap(1, g);
		chk(g, 8);
		w(clkrst_pkg::OFF_P0_CFG, 32'h0030_0000);
		w(clkrst_pkg::OFF_P0_RST, 32'hffff_ffff);
		@(negedge aclk);
		chk(first_periph_reset, 9'h1ff);
		watch(7, 40, g);
		chk(g >= 5 && g <= 16, 1'b1);
		r(clkrst_pkg::OFF_P0_RST, 32'h0000_0000);
		$display("t_rst done");
	endtask
	task automatic report_and_stop();
		$display("checks=%0d errors=%0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	initial begin
		aresetn = 1'b0;
		monitor = '0;
		rst();
		t_regs();
		t_status();
		t_core();
		t_pbus();
		t_gates();
		t_rst();
		report_and_stop();
	end
endmodule
